// ### include/cpp_pkg.sv
// constants shared by the colour palette pixel path
// assumes one pixel clock; host strobes and data arrive from pins

package cpp_pkg;
    // ****************************************************************
    // widths and sizes
    // ****************************************************************
    localparam int unsigned INDEX_W      = 8;
    localparam int unsigned COMP_W       = 6;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned SEL_W        = 2;
    localparam int unsigned ENTRIES      = 256;
    localparam int unsigned SYNC_STAGES  = 3;
    localparam int unsigned PIPE_STAGES  = 3;

    // ****************************************************************
    // register select codes
    // ****************************************************************
    localparam logic [1:0] SEL_ADDR      = 2'h0;
    localparam logic [1:0] SEL_COLOUR    = 2'h1;
    localparam logic [1:0] SEL_MASK      = 2'h2;
    localparam logic [1:0] SEL_ADDR_ALT  = 2'h3;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] MASK_RESET    = 8'hFF;
    localparam logic [7:0] ADDR_RESET    = 8'h00;

    // colour component order within one palette entry
    typedef enum logic [1:0] {
        CPP_COMP_RED   = 2'b00,
        CPP_COMP_GREEN = 2'b01,
        CPP_COMP_BLUE  = 2'b10
    } cpp_comp_e;
endpackage

// ### rtl/cpp_palette.sv
// colour palette pixel path with host programming port
// assumes clk_i is the pixel clock; host strobes, selects and data are asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module cpp_palette (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic [cpp_pkg::INDEX_W-1:0]   pixel_index_i,
    input  wire logic                          blank_n_i,
    output logic      [cpp_pkg::COMP_W-1:0]    red_code_o,
    output logic      [cpp_pkg::COMP_W-1:0]    green_code_o,
    output logic      [cpp_pkg::COMP_W-1:0]    blue_code_o,
    input  wire logic                          read_strobe_n_i,
    input  wire logic                          write_strobe_n_i,
    input  wire logic [cpp_pkg::SEL_W-1:0]     register_select_i,
    input  wire logic [cpp_pkg::DATA_W-1:0]    host_data_bus_i,
    output logic      [cpp_pkg::DATA_W-1:0]    host_data_bus_o,
    output logic                               host_data_bus_oe_n_o
);
    import cpp_pkg::*;

    // ****************************************************************
    // host pin synchronisers
    // ****************************************************************
    logic [1:0]        strobes_n;
    logic [SEL_W-1:0]  sel_sync;
    logic [DATA_W-1:0] data_sync;
    logic [1:0]        strobes_n_d;

    cpp_pin_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync_strobe (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({read_strobe_n_i, write_strobe_n_i}),
        .level_o (strobes_n)
    );

    cpp_pin_sync #(.WIDTH(SEL_W), .RESET_VAL(2'h0)) u_sync_sel (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (register_select_i),
        .level_o (sel_sync)
    );

    // data goes through the same depth as the strobes, so the sample at the strobe edge lines up
    cpp_pin_sync #(.WIDTH(DATA_W), .RESET_VAL(8'h00)) u_sync_data (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (host_data_bus_i),
        .level_o (data_sync)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strobes_n_d <= 2'h3;
        end else begin
            strobes_n_d <= strobes_n;
        end
    end

    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    logic rd_active;

    // both strobes together is a host fault; write takes the lead then
    assign rd_fall   = strobes_n_d[1] & ~strobes_n[1] & strobes_n[0];
    assign rd_rise   = ~strobes_n_d[1] & strobes_n[1];
    assign wr_fall   = strobes_n_d[0] & ~strobes_n[0];
    assign wr_rise   = ~strobes_n_d[0] & strobes_n[0];
    assign rd_active = ~strobes_n[1] & strobes_n[0];

    // ****************************************************************
    // register select capture
    // ****************************************************************
    logic [SEL_W-1:0] sel_held;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_held <= SEL_ADDR;
        end else if (rd_fall || wr_fall) begin
            sel_held <= sel_sync;
        end
    end

    logic hit_addr;
    logic hit_colour;
    logic hit_mask;

    always_comb begin
        hit_addr   = 1'b0;
        hit_colour = 1'b0;
        hit_mask   = 1'b0;
        if (sel_held == SEL_ADDR || sel_held == SEL_ADDR_ALT) begin
            hit_addr = 1'b1;
        end else if (sel_held == SEL_COLOUR) begin
            hit_colour = 1'b1;
        end else if (sel_held == SEL_MASK) begin
            hit_mask = 1'b1;
        end
    end

    // ****************************************************************
    // host registers
    // ****************************************************************
    logic [COMP_W*3-1:0] palette [ENTRIES];
    logic [INDEX_W-1:0]  addr;
    logic [INDEX_W-1:0]  mask;
    cpp_comp_e           comp;
    logic [COMP_W-1:0]   red_hold;
    logic [COMP_W-1:0]   green_hold;
    logic                colour_step;
    logic                colour_wr;

    assign colour_step = hit_colour & ((wr_rise) | rd_rise);
    assign colour_wr   = hit_colour & wr_rise & (comp == CPP_COMP_BLUE);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mask <= MASK_RESET;
        end else if (wr_rise && hit_mask) begin
            mask <= data_sync;
        end
    end

    // one address and one component counter serve both reads and writes; a fresh address restarts at red
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr <= ADDR_RESET;
            comp <= CPP_COMP_RED;
        end else if (wr_rise && hit_addr) begin
            addr <= data_sync;
            comp <= CPP_COMP_RED;
        end else if (colour_step) begin
            if (comp == CPP_COMP_BLUE) begin
                comp <= CPP_COMP_RED;
                addr <= addr + 8'h01;
            end else if (comp == CPP_COMP_GREEN) begin
                comp <= CPP_COMP_BLUE;
            end else begin
                comp <= CPP_COMP_GREEN;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            red_hold   <= '0;
            green_hold <= '0;
        end else if (wr_rise && hit_colour) begin
            if (comp == CPP_COMP_RED) begin
                red_hold <= data_sync[COMP_W-1:0];
            end else if (comp == CPP_COMP_GREEN) begin
                green_hold <= data_sync[COMP_W-1:0];
            end
        end
    end

    // table contents are left to software; no reset on the array
    always_ff @(posedge clk_i) begin
        if (colour_wr) begin
            palette[addr] <= {red_hold, green_hold, data_sync[COMP_W-1:0]};
        end
    end

    // ****************************************************************
    // host read port
    // ****************************************************************
    logic [COMP_W*3-1:0] host_entry;
    logic [DATA_W-1:0]   next_read_data;

    assign host_entry = palette[addr];

    always_comb begin
        next_read_data = 8'h00;
        if (hit_addr) begin
            next_read_data = addr;
        end else if (hit_mask) begin
            next_read_data = mask;
        end else if (hit_colour) begin
            if (comp == CPP_COMP_RED) begin
                next_read_data = {2'h0, host_entry[COMP_W*3-1:COMP_W*2]};
            end else if (comp == CPP_COMP_GREEN) begin
                next_read_data = {2'h0, host_entry[COMP_W*2-1:COMP_W]};
            end else begin
                next_read_data = {2'h0, host_entry[COMP_W-1:0]};
            end
        end
    end

    // bus is driven only while the read strobe is low and let go once it rises
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            host_data_bus_o      <= 8'h00;
            host_data_bus_oe_n_o <= 1'b1;
        end else begin
            host_data_bus_o      <= next_read_data;
            host_data_bus_oe_n_o <= ~(rd_active && !rd_fall);
        end
    end

    // ****************************************************************
    // pixel pipeline
    // ****************************************************************
    logic [INDEX_W-1:0]  pix_s1;
    logic                blank_n_s1;
    logic [COMP_W*3-1:0] colour_s2;
    logic                blank_n_s2;

    // stage one: sample pins on the pixel clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pix_s1     <= 8'h00;
            blank_n_s1 <= 1'b0;
        end else begin
            pix_s1     <= pixel_index_i;
            blank_n_s1 <= blank_n_i;
        end
    end

    // stage two: masked look-up; a mask change lands between pixels, never mid-address
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            colour_s2  <= '0;
            blank_n_s2 <= 1'b0;
        end else begin
            colour_s2  <= palette[pix_s1 & mask];
            blank_n_s2 <= blank_n_s1;
        end
    end

    // stage three: blank forcing onto the converter codes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            red_code_o   <= 6'h00;
            green_code_o <= 6'h00;
            blue_code_o  <= 6'h00;
        end else if (!blank_n_s2) begin
            red_code_o   <= 6'h00;
            green_code_o <= 6'h00;
            blue_code_o  <= 6'h00;
        end else begin
            red_code_o   <= colour_s2[COMP_W*3-1:COMP_W*2];
            green_code_o <= colour_s2[COMP_W*2-1:COMP_W];
            blue_code_o  <= colour_s2[COMP_W-1:0];
        end
    end
endmodule // cpp_palette

`default_nettype wire

// ### rtl/cpp_pin_sync.sv
// three flip-flop pin synchroniser with agreement filter
// assumes the input comes from outside the clk_i domain
`timescale 1ns/10ps
`default_nettype none

module cpp_pin_sync #(
    parameter int unsigned        WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta   <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            meta   <= pin_i;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_o <= RESET_VAL;
        end else if (stage2 == stage3) begin
            level_o <= stage3;
        end
    end
endmodule // cpp_pin_sync

`default_nettype wire

// ### test/colour_palette_pixel_path_tb.sv
// self-checking bench for the colour palette pixel path
// assumes the host model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module colour_palette_pixel_path_tb;
    import cpp_pkg::*;
    localparam logic [17:0] C4 = {6'h11, 6'h22, 6'h33};
    localparam logic [17:0] C7 = {6'h3F, 6'h00, 6'h2A};
    logic       clk_i, rst_n_i, blank_n_i, rd_n, wr_n, oe_n;
    logic [7:0] pixel_index_i, host_d, dev_d, bus, d;
    logic [1:0] sel;
    logic [5:0] red, green, blue;
    int         bad_count = 0;
    int         n_compared = 0;
    int         cycles = 0;
    // ****************************************************************
    // harness
    // ****************************************************************
    assign bus = oe_n ? host_d : dev_d;
    cpp_palette i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pixel_index_i(pixel_index_i),
        .blank_n_i(blank_n_i), .red_code_o(red), .green_code_o(green), .blue_code_o(blue),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .register_select_i(sel),
        .host_data_bus_i(bus), .host_data_bus_o(dev_d), .host_data_bus_oe_n_o(oe_n));
    cpp_host_model i_host (.clk_i(clk_i), .bus_i(bus), .read_strobe_n_o(rd_n),
        .write_strobe_n_o(wr_n), .select_o(sel), .data_o(host_d));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic load(input logic [1:0] s, input logic [7:0] a, input logic [17:0] c);
        i_host.wr(s, a);
        // upper data bits set on purpose: only six bits may be kept
        for (int k = 2; k >= 0; k--) i_host.wr(SEL_COLOUR, {2'h3, c[k*6 +: 6]});
    endtask
    task automatic pix(input logic [7:0] i, input logic b, input logic [17:0] e);
        @(negedge clk_i);
        pixel_index_i = i;
        blank_n_i = b;
        repeat (6) @(negedge clk_i);
        `CHK("codes", e, {red, green, blue})
    endtask
    task automatic t_reset();
        `CHK("reset codes", 18'h0, {red, green, blue})
        `CHK("reset oe_n", 1'b1, oe_n)
        rst_n_i = 1'b1;
        i_host.rd(SEL_MASK, d);
        `CHK("mask", MASK_RESET, d)
    endtask
    task automatic t_palette();
        load(SEL_ADDR, 8'h04, C4);
        load(SEL_ADDR_ALT, 8'h07, C7);
        i_host.wr(SEL_ADDR_ALT, 8'h04);
        for (int k = 2; k >= 0; k--) begin
            i_host.rd(SEL_COLOUR, d);
            `CHK("colour read", {2'h0, C4[k*6 +: 6]}, d)
        end
        // address moved on past blue; read back through the other select code
        i_host.rd(SEL_ADDR, d);
        `CHK("address", 8'h05, d)
        pix(8'h04, 1'b1, C4);
        pix(8'h07, 1'b1, C7);
    endtask
    task automatic t_mask();
        i_host.wr(SEL_MASK, 8'h04);
        pix(8'h07, 1'b1, C4);
        pix(8'hFC, 1'b1, C4);
        i_host.rd(SEL_MASK, d);
        `CHK("mask", 8'h04, d)
        i_host.wr(SEL_MASK, 8'hFF);
    endtask
    task automatic t_blank();
        pix(8'h07, 1'b0, 18'h0);
        pix(8'h07, 1'b1, C7);
        blank_n_i = 1'b0;
        @(negedge clk_i);
        blank_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK("blank pulse", 18'h0, {red, green, blue})
        @(negedge clk_i);
        `CHK("after pulse", C7, {red, green, blue})
    endtask
    initial begin
        rst_n_i = 1'b0;
        // blanked until the table is loaded, since the table has no reset
        blank_n_i = 1'b0;
        pixel_index_i = 8'h00;
        repeat (10) @(negedge clk_i);
        t_reset();
        t_palette();
        t_mask();
        t_blank();
        print_verdict();
    end
endmodule // colour_palette_pixel_path_tb
`default_nettype wire

// ### test/cpp_host_model.sv
// host processor model for the palette programming port
// assumes the bench resolves the data bus; pins move at falling edges
`timescale 1ns/10ps
`default_nettype none
module cpp_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] bus_i,
    output logic            read_strobe_n_o,
    output logic            write_strobe_n_o,
    output logic [1:0]      select_o,
    output logic [7:0]      data_o
);
    // ****************************************************************
    // bus cycles
    // ****************************************************************
    initial begin
        read_strobe_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        select_o = 2'h0;
        data_o = 8'h00;
    end
    // strobes and gaps of 10 clocks keep the spacing in pixel clocks
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clk_i);
        select_o = sel;
        data_o = d;
        write_strobe_n_o = 1'b0;
        repeat (10) @(negedge clk_i);
        write_strobe_n_o = 1'b1;
        repeat (10) @(negedge clk_i);
        data_o = ~d; // released lines show no stale value
        select_o = ~sel;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clk_i);
        select_o = sel;
        read_strobe_n_o = 1'b0;
        repeat (10) @(negedge clk_i);
        d = bus_i;
        read_strobe_n_o = 1'b1;
        repeat (10) @(negedge clk_i);
        select_o = ~sel;
    endtask
endmodule // cpp_host_model
`default_nettype wire

// ### test/cpp_palette_properties.sv
// port checker for the colour palette pixel path
// assumes one pixel clock and the host spacing kept by the bench
`timescale 1ns/10ps
`default_nettype none
module cpp_palette_properties (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic [cpp_pkg::INDEX_W-1:0] pixel_index_i,
    input wire logic                        blank_n_i,
    input wire logic [cpp_pkg::COMP_W-1:0]  red_code_o,
    input wire logic [cpp_pkg::COMP_W-1:0]  green_code_o,
    input wire logic [cpp_pkg::COMP_W-1:0]  blue_code_o,
    input wire logic                        read_strobe_n_i,
    input wire logic                        write_strobe_n_i,
    input wire logic                        host_data_bus_oe_n_o
);
    import cpp_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ****************************************************************
    // properties
    // ****************************************************************
    logic       codes_zero;
    logic [3:0] quiet_cnt;
    assign codes_zero = ({red_code_o, green_code_o, blue_code_o} == 18'h0);
    // a late synced write may still land in the palette, so wait long
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !blank_n_i || !write_strobe_n_i || !$stable(pixel_index_i)) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    // a blank seen at one edge reaches the codes two edges later, read at the third
    property p_blank_zero; !blank_n_i |-> ##3 codes_zero; endproperty
    property p_pipe_depth; $rose(blank_n_i) |-> ##2 codes_zero; endproperty
    property p_codes_hold;
        quiet_cnt >= 4'hC |-> $stable({red_code_o, green_code_o, blue_code_o});
    endproperty
    property p_read_drive;
        $fell(read_strobe_n_i) && write_strobe_n_i |-> ##[2:10] !host_data_bus_oe_n_o;
    endproperty
    property p_read_hold;
        (!read_strobe_n_i && write_strobe_n_i)[*8] |-> !host_data_bus_oe_n_o;
    endproperty
    property p_read_release;
        $rose(read_strobe_n_i) |-> !host_data_bus_oe_n_o ##[1:8] host_data_bus_oe_n_o;
    endproperty
    property p_idle_release; read_strobe_n_i[*8] |-> host_data_bus_oe_n_o; endproperty
    property p_write_silent; !write_strobe_n_i |-> host_data_bus_oe_n_o; endproperty
    a_blank_zero: assert property (p_blank_zero)
        else $error("codes not zero after blank");
    a_pipe_depth: assert property (p_pipe_depth)
        else $error("pipeline shorter than expected");
    a_codes_hold: assert property (p_codes_hold)
        else $error("codes moved with steady input");
    a_read_drive: assert property (p_read_drive)
        else $error("bus not driven in read");
    a_read_hold: assert property (p_read_hold)
        else $error("bus released during read");
    a_read_release: assert property (p_read_release)
        else $error("bus not released after read");
    a_idle_release: assert property (p_idle_release)
        else $error("bus driven while idle");
    a_write_silent: assert property (p_write_silent)
        else $error("bus driven during write");
    c_blank: cover property (p_blank_zero);
    c_read: cover property ($rose(read_strobe_n_i));
    c_write: cover property ($rose(write_strobe_n_i));
endmodule // cpp_palette_properties

bind cpp_palette cpp_palette_properties i_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pixel_index_i(pixel_index_i), .blank_n_i(blank_n_i),
    .red_code_o(red_code_o), .green_code_o(green_code_o), .blue_code_o(blue_code_o),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .host_data_bus_oe_n_o(host_data_bus_oe_n_o)
);
`default_nettype wire
